// >>> src/phy_ctrl_pkg.sv
// shared constants and types for the interface and otg control logic
package phy_ctrl_pkg;

   localparam int REG_WIDTH = 8;
   localparam int ADDR_WIDTH = 6;

   // register addresses: write, set, clear in a row
   localparam logic [5:0] MODE_CTRL_WRITE_ADDR = 6'h07;
   localparam logic [5:0] MODE_CTRL_SET_ADDR = 6'h08;
   localparam logic [5:0] MODE_CTRL_CLEAR_ADDR = 6'h09;
   localparam logic [5:0] OTG_FUNCTION_CONTROL_WRITE_ADDR = 6'h0a;
   localparam logic [5:0] OTG_FUNCTION_CONTROL_SET_ADDR = 6'h0b;
   localparam logic [5:0] OTG_FUNCTION_CONTROL_CLEAR_ADDR = 6'h0c;

   // values after reset, and the value read at an unmapped address
   localparam logic [7:0] MODE_CTRL_RESET = 8'h00;
   localparam logic [7:0] OTG_FUNCTION_CONTROL_RESET = 8'h06;
   localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

   // mode control fields
   localparam int MODE_CARKIT_BIT = 2;
   localparam int MODE_THREE_WIRE_BIT = 1;
   localparam int MODE_SIX_WIRE_BIT = 0;
   localparam logic [7:0] MODE_ALT_MASK = 8'h07;

   // otg control fields
   localparam int OTG_EXT_IND_SEL_BIT = 7;
   localparam int OTG_EXT_VBUS_DRIVE_BIT = 6;
   localparam int OTG_VBUS_CHARGE_BIT = 4;
   localparam int OTG_VBUS_DISCHARGE_BIT = 3;
   localparam int OTG_MINUS_PULLDOWN_BIT = 2;
   localparam int OTG_PLUS_PULLDOWN_BIT = 1;
   localparam int OTG_CABLE_ENABLE_BIT = 0;

   // command byte on the link data bus
   localparam int CMD_TYPE_MSB = 7;
   localparam int CMD_TYPE_LSB = 6;
   localparam logic [1:0] CMD_REG_WRITE = 2'h2;
   localparam logic [1:0] CMD_REG_READ = 2'h3;
   localparam logic [7:0] BUS_IDLE_VALUE = 8'h00;

   // register operation decoded from an address
   typedef enum logic [1:0] {
      OP_NONE,
      OP_WRITE,
      OP_SET,
      OP_CLEAR
   } reg_op_t;

   // register port sequencer
   typedef enum logic [2:0] {
      PS_IDLE,
      PS_ACK,
      PS_WR_DATA,
      PS_WR_STOP,
      PS_RD_TURN,
      PS_RD_DATA,
      PS_RD_END
   } port_state_t;

endpackage

// >>> src/level_sync.sv
// two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/10ps
module level_sync
   import phy_ctrl_pkg::*;
#(
   parameter int WIDTH = 3
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_reg;

   // first stage feeds only the second stage
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         meta_reg <= '0;
         sync_out <= '0;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end

endmodule

// >>> src/wsc_register.sv
// one control register with write, set and clear access plus hardware clear
`timescale 1ns/10ps
module wsc_register
   import phy_ctrl_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire reg_op_t op,
   input wire logic [WIDTH-1:0] wdata,
   input wire logic [WIDTH-1:0] hw_clear,
   output logic [WIDTH-1:0] value_reg
);

   logic [WIDTH-1:0] value_next;
   logic [WIDTH-1:0] sw_value;

   always_comb begin
      unique case (op)
         OP_WRITE: sw_value = wdata;
         OP_SET: sw_value = value_reg | wdata; // [R19]
         OP_CLEAR: sw_value = value_reg & ~wdata; // [R19]
         OP_NONE: sw_value = value_reg;
      endcase
      // hardware clear applies on top of any command and wins over it in the same cycle
      value_next = sw_value & ~hw_clear;
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         value_reg <= RESET_VALUE;
      end else begin
         value_reg <= value_next;
      end
   end

endmodule

// >>> src/phy_iface_otg_control.sv
// interface-mode and otg control registers behind the link register port
//
// Overview of operation
// R01: carkit mode bit set switches the link interface to the uart-style carkit interface.
// R02: device clears the carkit mode bit itself when carkit mode is exited.
// R03: link updates carkit transmit and receive enables whenever it changes carkit mode.
// R04: three-wire bit set sends full/low-speed packets over 3-bit serial, else parallel.
// R05: device clears the three-wire serial bit itself when that mode is exited.
// R06: six-wire bit set uses 6-bit serial; device clears it on mode exit.
// R07: mode control reads at 07h-09h, writes 07h, sets 08h, clears 09h.
// R08: otg control reads at 0ah-0ch, writes 0ah, sets 0bh, clears 0ch.
// R09: otg control resets with both pull-down enables at 1, all else 0.
// R10: indicator select bit chooses internal comparator or fault pin as vbus status.
// R11: external vbus drive bit pulls the active-low power switch output low.
// R12: link checks vbus discharged and 2 ms of se0 before vbus charge.
// R13: link waits for session end rising after discharge, then clears discharge.
// R14: a weak id pull-up stays on even with the cable enable bit clear.
// R15: link must set the cable enable bit, not rely on the weak pull-up.
// R16: link never sets more than one alternative mode bit at once.
// R17: cable enable bit connects id pull-up and enables id sampling.
// R18: each pull-down enable bit connects its 15 kilohm data-line pull-down.
// R19: set address ors data in, clear address clears bits written as 1.
// R20: read, set or clear address of a register all read its contents.
`timescale 1ns/10ps
module phy_iface_otg_control
   import phy_ctrl_pkg::*;
(
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic [7:0] ulpi_data_in,
   output logic [7:0] ulpi_data_out,
   output logic ulpi_data_oe,
   output logic ulpi_dir,
   output logic ulpi_nxt,
   input wire logic ulpi_stp,
   input wire logic fault_in,
   input wire logic comparator_vbus_valid,
   input wire logic session_end_indication,
   output logic power_switch_out_n,
   output logic vbus_charge,
   output logic vbus_discharge,
   output logic minus_line_pulldown_enable,
   output logic plus_line_pulldown_enable,
   output logic cable_enable_a,
   output logic id_sample_enable,
   output logic weak_cable_enable_a_enable,
   output logic carkit_mode_active,
   output logic three_wire_serial_active,
   output logic six_wire_serial_active,
   output logic vbus_valid_status,
   output logic session_end_status
);

   // address decode shared by both registers
   function automatic reg_op_t decode_op(
      input logic [5:0] addr,
      input logic [5:0] write_addr,
      input logic [5:0] set_addr,
      input logic [5:0] clear_addr
   );
      reg_op_t op;
      op = OP_NONE;
      if (addr == write_addr) begin
         op = OP_WRITE;
      end else if (addr == set_addr) begin
         op = OP_SET;
      end else if (addr == clear_addr) begin
         op = OP_CLEAR;
      end
      return op;
   endfunction

   port_state_t state_reg;
   port_state_t state_next;
   logic [5:0] addr_reg;
   logic [7:0] wdata_reg;
   logic stp_prev_reg;
   logic addr_is_read_reg;

   logic [7:0] mode_value;
   logic [7:0] otg_value;
   logic [2:0] pins_sync;

   // synchronised pin levels
   wire fault_sync = pins_sync[2];
   wire comparator_sync = pins_sync[1];
   wire session_end_sync = pins_sync[0];

   // alternative interface in use: the data bus belongs to that mode
   wire mode_any = |(mode_value & MODE_ALT_MASK);

   // a fresh stop while an alternative mode runs ends that mode
   wire stp_rise = ulpi_stp & ~stp_prev_reg;
   wire mode_exit = mode_any & stp_rise & (state_reg == PS_IDLE);

   // command byte recognition, only in the synchronous register mode
   wire [1:0] cmd_type = ulpi_data_in[CMD_TYPE_MSB:CMD_TYPE_LSB];
   wire cmd_ok = (state_reg == PS_IDLE) & ~mode_any;
   wire cmd_write = cmd_ok & (cmd_type == CMD_REG_WRITE);
   wire cmd_read = cmd_ok & (cmd_type == CMD_REG_READ);
   // a command byte seen outside idle is dropped, so no request queues up

   // the write lands when the link stops the transfer
   wire commit = (state_reg == PS_WR_STOP) & ulpi_stp;

   // per-register decode of the latched address
   wire reg_op_t mode_addr_op = decode_op(addr_reg, MODE_CTRL_WRITE_ADDR,
      MODE_CTRL_SET_ADDR, MODE_CTRL_CLEAR_ADDR); // [R07]
   wire reg_op_t otg_addr_op = decode_op(addr_reg, OTG_FUNCTION_CONTROL_WRITE_ADDR,
      OTG_FUNCTION_CONTROL_SET_ADDR, OTG_FUNCTION_CONTROL_CLEAR_ADDR); // [R08]
   wire reg_op_t mode_op = commit ? mode_addr_op : OP_NONE; // [R07]
   wire reg_op_t otg_op = commit ? otg_addr_op : OP_NONE; // [R08]

   // any of the three addresses of a register reads its contents
   wire [7:0] read_data = (mode_addr_op != OP_NONE) ? mode_value :
      (otg_addr_op != OP_NONE) ? otg_value : UNMAPPED_READ_VALUE; // [R20]

   // all alternative mode bits drop together when the mode ends
   wire [7:0] mode_hw_clear = mode_exit ? MODE_ALT_MASK : 8'h00; // [R02] [R05] [R06]

   level_sync #(
      .WIDTH(3)
   ) u_pin_sync (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .async_in({fault_in, comparator_vbus_valid, session_end_indication}),
      .sync_out(pins_sync)
   );

   wsc_register #(
      .WIDTH(REG_WIDTH),
      .RESET_VALUE(MODE_CTRL_RESET)
   ) u_mode_ctrl (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .op(mode_op),
      .wdata(wdata_reg),
      .hw_clear(mode_hw_clear),
      .value_reg(mode_value)
   );

   wsc_register #(
      .WIDTH(REG_WIDTH),
      .RESET_VALUE(OTG_FUNCTION_CONTROL_RESET)
   ) u_otg_function_control (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .op(otg_op),
      .wdata(wdata_reg),
      .hw_clear(8'h00),
      .value_reg(otg_value)
   ); // [R09]

   // register port sequencer
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         PS_IDLE: begin
            if (cmd_write || cmd_read) begin
               state_next = PS_ACK;
            end
         end
         PS_ACK: begin
            state_next = addr_is_read_reg ? PS_RD_TURN : PS_WR_DATA;
         end
         PS_WR_DATA: begin
            state_next = PS_WR_STOP;
         end
         PS_WR_STOP: begin
            // a link that never stops leaves the write pending
            if (ulpi_stp) begin
               state_next = PS_IDLE;
            end
         end
         PS_RD_TURN: begin
            state_next = PS_RD_DATA;
         end
         PS_RD_DATA: begin
            state_next = PS_RD_END;
         end
         PS_RD_END: begin
            state_next = PS_IDLE;
         end
         // the eighth code cannot be reached; fall back to idle if it is
         default: begin
            state_next = PS_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg <= PS_IDLE;
         stp_prev_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         stp_prev_reg <= ulpi_stp;
      end
   end

   // command capture
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         addr_reg <= 6'h00;
         addr_is_read_reg <= 1'b0;
      end else if (cmd_write || cmd_read) begin
         addr_reg <= ulpi_data_in[5:0];
         addr_is_read_reg <= cmd_read;
      end
   end

   // write data is taken in the cycle after the acknowledge
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wdata_reg <= 8'h00;
      end else if (state_reg == PS_WR_DATA) begin
         wdata_reg <= ulpi_data_in;
      end
   end

   // link-side next values come from the next state so the pins leave flops
   // the data bus is only driven in the cycle that carries read data
   wire nxt_next = (state_next == PS_ACK) || (state_next == PS_WR_DATA);
   wire dir_next = (state_next == PS_RD_TURN) || (state_next == PS_RD_DATA);
   wire oe_next = (state_next == PS_RD_DATA);
   wire [7:0] data_out_next = oe_next ? read_data : BUS_IDLE_VALUE; // [R20]

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ulpi_nxt <= 1'b0;
         ulpi_dir <= 1'b0;
         ulpi_data_oe <= 1'b0;
         ulpi_data_out <= BUS_IDLE_VALUE;
      end else begin
         ulpi_nxt <= nxt_next;
         ulpi_dir <= dir_next;
         ulpi_data_oe <= oe_next;
         ulpi_data_out <= data_out_next;
      end
   end

   // supply outputs, one flop behind the register
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         power_switch_out_n <= ~OTG_FUNCTION_CONTROL_RESET[OTG_EXT_VBUS_DRIVE_BIT];
         vbus_charge <= OTG_FUNCTION_CONTROL_RESET[OTG_VBUS_CHARGE_BIT];
         vbus_discharge <= OTG_FUNCTION_CONTROL_RESET[OTG_VBUS_DISCHARGE_BIT];
      end else begin
         power_switch_out_n <= ~otg_value[OTG_EXT_VBUS_DRIVE_BIT]; // [R11]
         // charge and discharge sequencing is up to the link
         vbus_charge <= otg_value[OTG_VBUS_CHARGE_BIT]; // [R12]
         vbus_discharge <= otg_value[OTG_VBUS_DISCHARGE_BIT]; // [R13]
      end
   end

   // line and id outputs, one flop behind the register
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         minus_line_pulldown_enable <= OTG_FUNCTION_CONTROL_RESET[OTG_MINUS_PULLDOWN_BIT];
         plus_line_pulldown_enable <= OTG_FUNCTION_CONTROL_RESET[OTG_PLUS_PULLDOWN_BIT];
         cable_enable_a <= OTG_FUNCTION_CONTROL_RESET[OTG_CABLE_ENABLE_BIT];
         id_sample_enable <= OTG_FUNCTION_CONTROL_RESET[OTG_CABLE_ENABLE_BIT];
         weak_cable_enable_a_enable <= 1'b1;
      end else begin
         minus_line_pulldown_enable <= otg_value[OTG_MINUS_PULLDOWN_BIT]; // [R18]
         plus_line_pulldown_enable <= otg_value[OTG_PLUS_PULLDOWN_BIT]; // [R18]
         cable_enable_a <= otg_value[OTG_CABLE_ENABLE_BIT]; // [R17]
         // sampling off saves power when the link leaves it clear
         id_sample_enable <= otg_value[OTG_CABLE_ENABLE_BIT]; // [R17]
         // weak pull-up never turns off so id is still seen
         weak_cable_enable_a_enable <= 1'b1; // [R14]
      end
   end

   // external indicator or internal comparator as vbus status
   wire vbus_status_sel = otg_value[OTG_EXT_IND_SEL_BIT] ? fault_sync : comparator_sync; // [R10]

   // mode selects
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         carkit_mode_active <= MODE_CTRL_RESET[MODE_CARKIT_BIT];
         three_wire_serial_active <= MODE_CTRL_RESET[MODE_THREE_WIRE_BIT];
         six_wire_serial_active <= MODE_CTRL_RESET[MODE_SIX_WIRE_BIT];
      end else begin
         // the cycle of exit already shows the parallel interface
         carkit_mode_active <= mode_value[MODE_CARKIT_BIT] & ~mode_exit; // [R01] [R02]
         three_wire_serial_active <= mode_value[MODE_THREE_WIRE_BIT] & ~mode_exit; // [R04]
         six_wire_serial_active <= mode_value[MODE_SIX_WIRE_BIT] & ~mode_exit; // [R06]
      end
   end

   // status outputs trail the pins by three edges
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         vbus_valid_status <= 1'b0;
         session_end_status <= 1'b0;
      end else begin
         vbus_valid_status <= vbus_status_sel;
         session_end_status <= session_end_sync;
      end
   end

endmodule

// >>> dv/otg_function_control_checker.sv
// assertions on the register port and control outputs
`timescale 1ns/10ps
module otg_function_control_checker
   import phy_ctrl_pkg::*;
(
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic ulpi_dir,
   input wire logic ulpi_nxt,
   input wire logic ulpi_data_oe,
   input wire logic ulpi_stp,
   input wire logic power_switch_out_n,
   input wire logic vbus_charge,
   input wire logic vbus_discharge,
   input wire logic minus_line_pulldown_enable,
   input wire logic plus_line_pulldown_enable,
   input wire logic cable_enable_a,
   input wire logic id_sample_enable,
   input wire logic weak_cable_enable_a_enable,
   input wire logic carkit_mode_active,
   input wire logic three_wire_serial_active,
   input wire logic six_wire_serial_active
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   wire logic alt_on = carkit_mode_active | three_wire_serial_active | six_wire_serial_active;
   wire logic [5:0] otg_pins = {power_switch_out_n, vbus_charge, vbus_discharge,
      minus_line_pulldown_enable, plus_line_pulldown_enable, cable_enable_a};
   property p_reset_vals;
      $past(sys_rst) |-> power_switch_out_n && minus_line_pulldown_enable &&
         plus_line_pulldown_enable && !cable_enable_a && !vbus_charge && !vbus_discharge;
   endproperty
   a_reset_vals: assert property (p_reset_vals) else $error("otg outputs wrong after reset");
   property p_id_sample;
      id_sample_enable == cable_enable_a;
   endproperty
   a_id_sample: assert property (p_id_sample) else $error("id sampling not tied to pull-up");
   property p_weak_pullup;
      weak_cable_enable_a_enable;
   endproperty
   a_weak_pullup: assert property (p_weak_pullup) else $error("weak id pull-up off");
   property p_mode_exit;
      ulpi_stp && !$past(ulpi_stp) && alt_on |=> !alt_on;
   endproperty
   a_mode_exit: assert property (p_mode_exit) else $error("mode not left on stop");
   property p_read_turn;
      $rose(ulpi_dir) |-> !ulpi_data_oe ##1 (ulpi_dir && ulpi_data_oe) ##1 !ulpi_dir;
   endproperty
   a_read_turn: assert property (p_read_turn) else $error("read turnaround wrong");
   property p_nxt_pair;
      $rose(ulpi_nxt) |=> (ulpi_nxt ##1 !ulpi_nxt) or ulpi_dir;
   endproperty
   a_nxt_pair: assert property (p_nxt_pair) else $error("accept strobe length wrong");
   property p_refuse;
      alt_on |-> !ulpi_nxt && !ulpi_dir;
   endproperty
   a_refuse: assert property (p_refuse) else $error("port active in alternative mode");
   // otg outputs move only two edges after a write commits on stop
   property p_otg_commit;
      $changed(otg_pins) |-> $past(ulpi_stp, 2);
   endproperty
   a_otg_commit: assert property (p_otg_commit) else $error("otg output moved alone");
   c_read: cover property ($rose(ulpi_dir));
   c_exit: cover property (alt_on ##1 !alt_on);
   c_psw: cover property ($fell(power_switch_out_n));
endmodule
bind phy_iface_otg_control otg_function_control_checker chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
   .ulpi_dir(ulpi_dir), .ulpi_nxt(ulpi_nxt), .ulpi_data_oe(ulpi_data_oe), .ulpi_stp(ulpi_stp),
   .power_switch_out_n(power_switch_out_n), .vbus_charge(vbus_charge),
   .vbus_discharge(vbus_discharge), .minus_line_pulldown_enable(minus_line_pulldown_enable),
   .plus_line_pulldown_enable(plus_line_pulldown_enable), .cable_enable_a(cable_enable_a),
   .id_sample_enable(id_sample_enable), .weak_cable_enable_a_enable(weak_cable_enable_a_enable),
   .carkit_mode_active(carkit_mode_active),
   .three_wire_serial_active(three_wire_serial_active),
   .six_wire_serial_active(six_wire_serial_active));

// >>> dv/link_model.sv
// behavioural link controller on the register port
`timescale 1ns/10ps
module link_model (
   input wire logic ref_clk,
   input wire logic ulpi_dir,
   input wire logic ulpi_nxt,
   input wire logic ulpi_data_oe,
   output logic [7:0] ulpi_data_in,
   output logic ulpi_stp,
   output logic hang
);
   initial begin
      ulpi_data_in = 8'h00;
      ulpi_stp = 1'b0;
      hang = 1'b0;
   end
   task automatic wait_hi(input logic rd);
      int n;
      logic got;
      n = 0;
      got = 1'b0;
      while (!got && n < 20) begin
         @(posedge ref_clk);
         got = rd ? ((ulpi_dir & ulpi_data_oe) === 1'b1) : (ulpi_nxt === 1'b1);
         n++;
      end
      if (!got) hang = 1'b1;
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      ulpi_data_in = {2'b10, a};
      wait_hi(1'b0);
      #1 ulpi_data_in = d;
      @(posedge ref_clk);
      #1 ulpi_data_in = 8'h00;
      ulpi_stp = 1'b1;
      @(posedge ref_clk);
      #1 ulpi_stp = 1'b0;
   endtask
   task automatic rd(input logic [5:0] a);
      ulpi_data_in = {2'b11, a};
      wait_hi(1'b0);
      // released bus never keeps the last value
      #1 ulpi_data_in = ~ulpi_data_in;
      wait_hi(1'b1);
      @(posedge ref_clk);
      #1 ulpi_data_in = 8'h00;
   endtask
   task automatic leave_mode();
      ulpi_stp = 1'b1;
      @(posedge ref_clk);
      #1 ulpi_stp = 1'b0;
   endtask
endmodule

// >>> dv/tb_top.sv
// self-checking bench for the interface and otg control registers
`timescale 1ns/10ps
module tb_top
   import phy_ctrl_pkg::*;
;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic fault_in = 1'b0, comparator_vbus_valid = 1'b0, session_end_indication = 1'b0;
   logic [7:0] ulpi_data_in, ulpi_data_out, otg_exp, mode_exp, d;
   logic ulpi_data_oe, ulpi_dir, ulpi_nxt, ulpi_stp, hang, vbus_valid_status, session_end_status;
   logic power_switch_out_n, vbus_charge, vbus_discharge, minus_line_pulldown_enable;
   logic plus_line_pulldown_enable, cable_enable_a, id_sample_enable, weak_cable_enable_a_enable;
   logic carkit_mode_active, three_wire_serial_active, six_wire_serial_active;
   logic [7:0] exp_q[$];
   int err_total = 0, compares = 0, seed = 32'h07793fb4;
   wire logic [2:0] alt_vec = {carkit_mode_active, three_wire_serial_active,
      six_wire_serial_active};
   wire logic [7:0] otg_pins = {power_switch_out_n, vbus_charge, vbus_discharge,
      minus_line_pulldown_enable, plus_line_pulldown_enable, cable_enable_a,
      id_sample_enable, weak_cable_enable_a_enable};
   phy_iface_otg_control DUT (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .ulpi_data_in(ulpi_data_in), .ulpi_data_out(ulpi_data_out), .ulpi_data_oe(ulpi_data_oe),
      .ulpi_dir(ulpi_dir), .ulpi_nxt(ulpi_nxt), .ulpi_stp(ulpi_stp), .fault_in(fault_in),
      .comparator_vbus_valid(comparator_vbus_valid),
      .session_end_indication(session_end_indication),
      .power_switch_out_n(power_switch_out_n), .vbus_charge(vbus_charge),
      .vbus_discharge(vbus_discharge), .minus_line_pulldown_enable(minus_line_pulldown_enable),
      .plus_line_pulldown_enable(plus_line_pulldown_enable), .cable_enable_a(cable_enable_a),
      .id_sample_enable(id_sample_enable), .weak_cable_enable_a_enable(weak_cable_enable_a_enable),
      .carkit_mode_active(carkit_mode_active),
      .three_wire_serial_active(three_wire_serial_active),
      .six_wire_serial_active(six_wire_serial_active), .vbus_valid_status(vbus_valid_status),
      .session_end_status(session_end_status));
   link_model link (.ref_clk(ref_clk), .ulpi_dir(ulpi_dir), .ulpi_nxt(ulpi_nxt),
      .ulpi_data_oe(ulpi_data_oe), .ulpi_data_in(ulpi_data_in), .ulpi_stp(ulpi_stp),
      .hang(hang));
   initial begin
      forever #10 ref_clk = ~ref_clk;
   end
   task automatic ck(input logic [7:0] got, input logic [7:0] want);
      compares++;
      if (got !== want) begin
         err_total++;
         $display("unexpected at %0t: got %h want %h", $time, got, want);
      end
   endtask
   task automatic close_out();
      // a read whose data never showed up is a mismatch too
      if (exp_q.size() != 0) err_total++;
      $display("mismatches %0d compares %0d", err_total, compares);
      if (err_total == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // a stalled handshake ends the run rather than hanging it
   task automatic hang_chk();
      if (hang) begin
         err_total++;
         close_out();
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] v);
      link.wr(a, v);
      hang_chk();
   endtask
   task automatic rd(input logic [5:0] a, input logic [7:0] want);
      exp_q.push_back(want);
      link.rd(a);
      hang_chk();
   endtask
   task automatic otg_chk();
      repeat (5) @(posedge ref_clk);
      #1;
      ck(otg_pins, {~otg_exp[6], otg_exp[4:0], otg_exp[0], 1'b1});
      ck(8'(vbus_valid_status), 8'(otg_exp[7] ? fault_in : comparator_vbus_valid));
      ck(8'(session_end_status), 8'(session_end_indication));
      for (int j = 0; j < 3; j++) rd(6'(OTG_FUNCTION_CONTROL_WRITE_ADDR + j), otg_exp);
   endtask
   // read data is taken mid-cycle, away from the edge that moves it
   always @(negedge ref_clk) begin
      if (ulpi_dir === 1'b1 && ulpi_data_oe === 1'b1) begin
         ck(ulpi_data_out, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
      end
   end
   initial begin
      repeat (12) @(posedge ref_clk);
      #1 sys_rst = 1'b0;
      otg_exp = OTG_FUNCTION_CONTROL_RESET;
      mode_exp = MODE_CTRL_RESET;
      otg_chk();
      rd(6'h20, UNMAPPED_READ_VALUE);
      wr(6'h15, 8'hff);
      for (int j = 0; j < 3; j++) rd(6'(MODE_CTRL_WRITE_ADDR + j), mode_exp);
      wr(OTG_FUNCTION_CONTROL_SET_ADDR, 8'h08);
      otg_exp = otg_exp | 8'h08;
      session_end_indication = 1'b1;
      otg_chk();
      wr(OTG_FUNCTION_CONTROL_CLEAR_ADDR, 8'h08);
      otg_exp = otg_exp & 8'hf7;
      wr(OTG_FUNCTION_CONTROL_SET_ADDR, 8'h10); // charge only once vbus is discharged
      otg_exp = otg_exp | 8'h10;
      otg_chk();
      wr(OTG_FUNCTION_CONTROL_CLEAR_ADDR, 8'h10);
      otg_exp = otg_exp & 8'hef;
      for (int i = 0; i < 9; i++) begin
         // charge and discharge stay with the sequence above
         d = 8'($random(seed)) & 8'he7;
         fault_in = 1'($random(seed));
         comparator_vbus_valid = 1'($random(seed));
         session_end_indication = 1'($random(seed));
         wr(6'(OTG_FUNCTION_CONTROL_WRITE_ADDR + i % 3), d);
         otg_exp = (i % 3 == 0) ? d : (i % 3 == 1) ? (otg_exp | d) : (otg_exp & ~d);
         otg_chk();
      end
      // carkit transmit and receive enables live outside this block
      for (int i = 0; i < 6; i++) begin
         d = (8'($random(seed)) & 8'hf8) | (8'h01 << (i % 3)); // one mode at a time
         wr(i < 3 ? MODE_CTRL_WRITE_ADDR : MODE_CTRL_SET_ADDR, d);
         mode_exp = (i < 3) ? d : (mode_exp | d);
         repeat (2) @(posedge ref_clk);
         #1;
         ck(8'(alt_vec), 8'(mode_exp[2:0]));
         link.leave_mode();
         mode_exp = mode_exp & 8'hf8;
         ck(8'(alt_vec), 8'h00);
         rd(6'(MODE_CTRL_WRITE_ADDR + i % 3), mode_exp);
         d = 8'($random(seed)) & 8'hf8;
         wr(MODE_CTRL_CLEAR_ADDR, d);
         mode_exp = mode_exp & ~d;
      end
      rd(MODE_CTRL_CLEAR_ADDR, mode_exp);
      wr(OTG_FUNCTION_CONTROL_SET_ADDR, 8'h01);
      otg_exp = otg_exp | 8'h01;
      otg_chk();
      close_out();
   end
endmodule
